// *** hw/bss_sequencer.sv ***
// Behaviour
// RULE_01 - high gate inhibits, low allows generation; a software trigger still starts a triggered-mode run or a sweep with gate high
// RULE_02 - gated: level to run; triggered: edge pulse
// RULE_03 - run high raises loop enable
// RULE_04 - square falling with gate high resets run
// RULE_05 - loop enable drops at next square rise
// RULE_06 - after drop, loop stops at clamp level
// RULE_07 - one sweep per start event
// RULE_08 - peak hold level replaces sweep output
// RULE_09 - trigger fires 10 us one-shot
// RULE_10 - one-shot end sets start-stop flip-flop
// RULE_11 - start-stop set: release clamp, actives high
// RULE_12 - sweep peak drops both active indications
// RULE_13 - drop resets ramp, start-stop, hold low
// RULE_14 - trigger sweep: next trigger releases hold
// RULE_15 - sweep and hold: reset control releases
// RULE_16 - synchronise all pin inputs first
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module bss_sequencer
  import bss_pkg::*;
(
  input wire logic clk_i, // 200 mhz clock
  input wire logic rst_n_i, // async reset, low
  input wire logic trig_gate_i, // trigger/gate level, high inhibits
  input wire logic loop_square_i, // main loop squarewave
  input wire logic sweep_peak_i, // sweep ramp at peak
  input wire logic sweep_reset_control_i, // sweep reset pushbutton
  output logic run_flip_flop_o, // run flip-flop
  output logic loop_enable_indication_o, // unlocks main loop
  output logic sweep_start_one_shot_o, // 10 us delay
  output logic sweep_start_stop_flip_flop_o, // start-stop flip-flop
  output logic sweep_clamp_release_o, // sweep clamp released
  output logic sweep_active_indication_a_o, // sweep active a
  output logic sweep_active_indication_b_o, // sweep active b
  output logic ramp_reset_o, // ramp held reset
  output logic peak_hold_flip_flop_o, // low selects held peak
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  function automatic logic is_single_sweep(input bss_mode_type m);
    is_single_sweep = (m == BSS_MODE_TRIG_SWEEP) || (m == BSS_MODE_SWEEP_HOLD);
  endfunction

  // sweep state decode shared by outputs and status
  function automatic logic sw_in_delay(input bss_sweep_type s);
    sw_in_delay = (s == BSS_SW_DELAY);
  endfunction
  function automatic logic sw_in_run(input bss_sweep_type s);
    sw_in_run = (s == BSS_SW_RUN);
  endfunction

  // two-stage synchronisers for the four pins
  // reset to each pin's idle level; a low gate out of reset would start a run
  logic [3:0] pins_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q;
  assign pins_raw = {sweep_reset_control_i, sweep_peak_i, loop_square_i, trig_gate_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sync1_q[gi] <= PIN_IDLE_LEVEL[gi]; // RULE_01
          sync2_q[gi] <= PIN_IDLE_LEVEL[gi];
          prev_q[gi] <= PIN_IDLE_LEVEL[gi];
        end else begin
          sync1_q[gi] <= pins_raw[gi]; // RULE_16
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  // synchronised levels
  logic gate_s, square_s, peak_s, sreset_s;
  logic square_fall, square_rise, peak_rise, sreset_rise;
  assign gate_s = sync2_q[0];
  assign square_s = sync2_q[1];
  assign peak_s = sync2_q[2];
  assign sreset_s = sync2_q[3];

  // edges against the previous sampled level
  assign square_fall = ~square_s & prev_q[1];
  assign square_rise = square_s & ~prev_q[1];
  assign peak_rise = peak_s & ~prev_q[2];
  assign sreset_rise = sreset_s & ~prev_q[3];

  // registers
  // mode comes straight from the control word
  logic [31:0] ctrl_q;
  logic soft_trig_q;
  bss_mode_type mode;
  assign mode = bss_mode_type'(ctrl_q[CTRL_MODE_LSB +: CTRL_MODE_W]);

  // trigger event: pin edge or software pulse; start when gate goes low
  // the software pulse lets the bus start a run in triggered mode or a sweep; gated mode ignores it
  logic trig_fall, trig_evt;
  assign trig_fall = ~gate_s & prev_q[0];
  assign trig_evt = trig_fall | soft_trig_q;

  // run flip-flop input per mode
  // triggered mode sees only the one-cycle trigger event, pin fall or software pulse
  logic run_in;
  always_comb begin
    case (mode)
      BSS_MODE_GATED: run_in = ~gate_s; // RULE_02 RULE_01
      BSS_MODE_TRIGGERED: run_in = trig_evt; // RULE_02
      default: run_in = 1'b0;
    endcase
  end

  // run flip-flop: set by input, reset on square fall while gate high
  // set wins over clear, so a low gate keeps the loop running in gated and triggered modes
  logic run_q, loop_en_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
    end else if (is_single_sweep(mode)) begin
      run_q <= 1'b0;
    end else if (run_in) begin
      run_q <= 1'b1; // RULE_01
    end else if (square_fall && gate_s) begin
      run_q <= 1'b0; // RULE_04
    end
  end

  // loop enable holds until square rises after run clears
  // dropping on the rise lets the triangle finish at the clamp level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_en_q <= 1'b0;
    end else if (run_q) begin
      loop_en_q <= 1'b1; // RULE_03
    end else if (square_rise) begin
      loop_en_q <= 1'b0; // RULE_05 RULE_06
    end
  end

  // single-sweep sequencer
  // triggers during the delay or the sweep are ignored: one sweep per start
  bss_sweep_type sw_q;
  logic [ONE_SHOT_CNT_W-1:0] os_cnt_q;
  logic hold_n_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_q <= BSS_SW_IDLE;
      os_cnt_q <= '0;
      hold_n_q <= 1'b1;
    end else if (!is_single_sweep(mode)) begin
      sw_q <= BSS_SW_IDLE;
      os_cnt_q <= '0;
      hold_n_q <= 1'b1;
    end else begin
      case (sw_q)
        BSS_SW_IDLE: begin
          if (trig_evt) begin
            sw_q <= BSS_SW_DELAY; // RULE_09 RULE_07
            os_cnt_q <= ONE_SHOT_CNT_W'(ONE_SHOT_CYCLES - 1);
          end
        end
        BSS_SW_DELAY: begin
          if (os_cnt_q == '0) begin
            sw_q <= BSS_SW_RUN; // RULE_10
          end else begin
            os_cnt_q <= os_cnt_q - 1'b1;
          end
        end
        BSS_SW_RUN: begin
          if (peak_rise) begin
            sw_q <= BSS_SW_HOLD; // RULE_12 RULE_13
            hold_n_q <= 1'b0; // RULE_08
          end
        end
        BSS_SW_HOLD: begin
          if (mode == BSS_MODE_TRIG_SWEEP && trig_evt) begin
            hold_n_q <= 1'b1; // RULE_14
            sw_q <= BSS_SW_DELAY;
            os_cnt_q <= ONE_SHOT_CNT_W'(ONE_SHOT_CYCLES - 1);
          end else if (mode == BSS_MODE_SWEEP_HOLD && sreset_rise) begin
            hold_n_q <= 1'b1; // RULE_15
            sw_q <= BSS_SW_IDLE;
          end
        end
        default: sw_q <= BSS_SW_IDLE;
      endcase
    end
  end

  // registered loop outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_flip_flop_o <= 1'b0;
      loop_enable_indication_o <= 1'b0;
    end else begin
      run_flip_flop_o <= run_q;
      loop_enable_indication_o <= loop_en_q; // RULE_03
    end
  end

  // registered sweep outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sweep_start_one_shot_o <= 1'b0;
      sweep_start_stop_flip_flop_o <= 1'b0;
      sweep_clamp_release_o <= 1'b0;
      sweep_active_indication_a_o <= 1'b0;
      sweep_active_indication_b_o <= 1'b0;
      ramp_reset_o <= 1'b1;
      peak_hold_flip_flop_o <= 1'b1;
    end else begin
      sweep_start_one_shot_o <= sw_in_delay(sw_q); // RULE_09
      sweep_start_stop_flip_flop_o <= sw_in_run(sw_q); // RULE_10
      sweep_clamp_release_o <= sw_in_run(sw_q); // RULE_11
      sweep_active_indication_a_o <= sw_in_run(sw_q); // RULE_11
      sweep_active_indication_b_o <= sw_in_run(sw_q); // RULE_11
      ramp_reset_o <= !sw_in_run(sw_q); // RULE_13
      peak_hold_flip_flop_o <= hold_n_q; // RULE_13
    end
  end

  // status word
  // live values, nothing latched for the read
  logic [31:0] status;
  always_comb begin
    status = 32'h00000000;
    status[STAT_RUN_BIT] = run_q;
    status[STAT_LOOP_EN_BIT] = loop_en_q;
    status[STAT_ONE_SHOT_BIT] = sw_in_delay(sw_q);
    status[STAT_SWEEP_BIT] = sw_in_run(sw_q);
    status[STAT_HOLD_N_BIT] = hold_n_q;
    status[STAT_GATE_BIT] = gate_s;
  end

  // axi write: take address and data in any order, respond after both
  // ready depends only on slave state, never on valid
  logic aw_got_q, w_got_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  // write response: one cycle after both halves are held
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_q == CTRL_OFFSET || aw_addr_q == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register and software trigger pulse
  // only byte 0 is writable; the trigger bit is a pulse and reads back 0
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RESET_VALUE;
      soft_trig_q <= 1'b0;
    end else begin
      soft_trig_q <= 1'b0;
      if (wr_fire && aw_addr_q == CTRL_OFFSET) begin
        if (w_strb_q[0]) begin
          ctrl_q[CTRL_MODE_LSB +: CTRL_MODE_W] <= w_data_q[CTRL_MODE_LSB +: CTRL_MODE_W];
          soft_trig_q <= w_data_q[CTRL_SOFT_TRIG_BIT];
        end
      end
    end
  end

  // axi read
  // unmapped offsets answer slverr with zero data
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        CTRL_OFFSET: begin
          s_axi_rdata <= ctrl_q;
          s_axi_rresp <= RESP_OKAY;
        end
        STATUS_OFFSET: begin
          s_axi_rdata <= status;
          s_axi_rresp <= RESP_OKAY;
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** hw/bss_pkg.sv ***
package bss_pkg;
  // clock and one-shot timing
  localparam int unsigned CLK_FREQ_HZ = 200000000;
  localparam int unsigned ONE_SHOT_US = 10;
  localparam int unsigned ONE_SHOT_CYCLES = (ONE_SHOT_US * (CLK_FREQ_HZ / 1000000));
  localparam int unsigned ONE_SHOT_CNT_W = 12;

  // idle levels of the synchronised pins {reset, peak, square, gate}: gate rests high
  localparam logic [3:0] PIN_IDLE_LEVEL = 4'h1;

  // register byte offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // control fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_MODE_W = 2;
  localparam int unsigned CTRL_SOFT_TRIG_BIT = 2;
  localparam logic [31:0] CTRL_RESET_VALUE = 32'h00000000;

  // status fields
  localparam int unsigned STAT_RUN_BIT = 0;
  localparam int unsigned STAT_LOOP_EN_BIT = 1;
  localparam int unsigned STAT_ONE_SHOT_BIT = 2;
  localparam int unsigned STAT_SWEEP_BIT = 3;
  localparam int unsigned STAT_HOLD_N_BIT = 4;
  localparam int unsigned STAT_GATE_BIT = 5;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // operating modes
  typedef enum logic [1:0] {
    BSS_MODE_GATED = 2'b00,
    BSS_MODE_TRIGGERED = 2'b01,
    BSS_MODE_TRIG_SWEEP = 2'b10,
    BSS_MODE_SWEEP_HOLD = 2'b11
  } bss_mode_type;

  // single-sweep states
  typedef enum logic [1:0] {
    BSS_SW_IDLE = 2'b00,
    BSS_SW_DELAY = 2'b01,
    BSS_SW_RUN = 2'b10,
    BSS_SW_HOLD = 2'b11
  } bss_sweep_type;
endpackage

// *** tb/bss_sequencer_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module bss_sequencer_chk
  import bss_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic trig_gate_i, // gate pin
  input wire logic loop_square_i, // loop square
  input wire logic sweep_peak_i, // peak pin
  input wire logic run_flip_flop_o, // run
  input wire logic loop_enable_indication_o, // loop enable
  input wire logic sweep_start_one_shot_o, // delay
  input wire logic sweep_start_stop_flip_flop_o, // start-stop
  input wire logic sweep_clamp_release_o, // clamp off
  input wire logic sweep_active_indication_a_o, // active a
  input wire logic peak_hold_flip_flop_o // hold
);
  int os_q;
  int sq_q;
  // one-shot length and cycles since square rose
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      os_q <= 0;
      sq_q <= 99;
    end else begin
      os_q <= sweep_start_one_shot_o ? os_q + 1 : 0;
      sq_q <= $rose(loop_square_i) ? 0 : (sq_q < 99 ? sq_q + 1 : 99);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // start-stop follows the end of the delay
  sequence ss_set_s;
    ##[0:1] sweep_start_stop_flip_flop_o;
  endsequence
  gate_low_a: assert property ($rose(run_flip_flop_o) |-> !trig_gate_i)
    else $error("run set while gate high");
  loop_en_a: assert property (run_flip_flop_o && $past(run_flip_flop_o) |-> loop_enable_indication_o)
    else $error("loop enable low while running");
  run_fall_a: assert property ($fell(run_flip_flop_o) |-> trig_gate_i)
    else $error("run cleared while gate low");
  loop_hold_a: assert property ($fell(loop_enable_indication_o) |-> sq_q < 8)
    else $error("loop enable dropped without square rise");
  os_len_a: assert property ($fell(sweep_start_one_shot_o) |-> os_q == ONE_SHOT_CYCLES)
    else $error("delay length wrong");
  ss_set_a: assert property ($fell(sweep_start_one_shot_o) |-> ss_set_s)
    else $error("start-stop not set after delay");
  active_a: assert property (sweep_start_stop_flip_flop_o |-> sweep_clamp_release_o && sweep_active_indication_a_o)
    else $error("clamp or active low during sweep");
  peak_drop_a: assert property ($rose(sweep_peak_i) && sweep_start_stop_flip_flop_o
    |-> ##[1:6] !sweep_active_indication_a_o)
    else $error("active not dropped at peak");
  hold_low_a: assert property ($fell(sweep_start_stop_flip_flop_o) |-> ##[0:1] !peak_hold_flip_flop_o)
    else $error("hold not selected at sweep end");
  one_sweep_a: assert property (sweep_start_one_shot_o |-> !sweep_start_stop_flip_flop_o)
    else $error("delay during running sweep");
endmodule
bind bss_sequencer bss_sequencer_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .trig_gate_i(trig_gate_i),
  .loop_square_i(loop_square_i), .sweep_peak_i(sweep_peak_i), .run_flip_flop_o(run_flip_flop_o),
  .loop_enable_indication_o(loop_enable_indication_o), .sweep_start_one_shot_o(sweep_start_one_shot_o),
  .sweep_start_stop_flip_flop_o(sweep_start_stop_flip_flop_o), .sweep_clamp_release_o(sweep_clamp_release_o),
  .sweep_active_indication_a_o(sweep_active_indication_a_o), .peak_hold_flip_flop_o(peak_hold_flip_flop_o));
`default_nettype wire

// *** tb/bss_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bss_panel_model #(
  parameter int HALF = 8,
  parameter int RAMP = 40
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic clamp_release_i, // ramp may climb
  output logic loop_square_o, // main loop square
  output logic sweep_peak_o // ramp at peak
);
  int sq_q;
  int ramp_q;
  // free-running main loop square
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sq_q <= 0;
      loop_square_o <= 1'b0;
    end else if (sq_q == HALF - 1) begin
      sq_q <= 0;
      loop_square_o <= !loop_square_o;
    end else begin
      sq_q <= sq_q + 1;
    end
  end
  // ramp climbs while released, collapses once clamped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ramp_q <= 0;
    end else begin
      ramp_q <= clamp_release_i ? ramp_q + 1 : 0;
    end
  end
  assign sweep_peak_o = (ramp_q >= RAMP);
endmodule
`default_nettype wire

// *** tb/bss_sequencer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module bss_sequencer_bench;
  import bss_pkg::*;
  logic clk, rst_n, gate, rst_ctl, sq, pk, run, len, os, ss, clr, aa, ab, rr, hold;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int fails, n_compared, cyc;
  bss_sequencer u_bss_sequencer (.clk_i(clk), .rst_n_i(rst_n), .trig_gate_i(gate), .loop_square_i(sq),
    .sweep_peak_i(pk), .sweep_reset_control_i(rst_ctl), .run_flip_flop_o(run), .loop_enable_indication_o(len),
    .sweep_start_one_shot_o(os), .sweep_start_stop_flip_flop_o(ss), .sweep_clamp_release_o(clr),
    .sweep_active_indication_a_o(aa), .sweep_active_indication_b_o(ab), .ramp_reset_o(rr),
    .peak_hold_flip_flop_o(hold), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  bss_panel_model u_bss_panel_model (.clk_i(clk), .rst_n_i(rst_n), .clamp_release_i(clr),
    .loop_square_o(sq), .sweep_peak_o(pk));
  task automatic final_report();
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // write: both channels offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      pa = pa && !awready;
      pw = pw && !wready;
      @(posedge clk);
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    chk("bresp", 32'(bresp), 32'(er));
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    chk("rresp", 32'(rresp), 32'(er));
    chk("rdata", rdata, ed);
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic pin_gate(input logic v);
    @(posedge clk);
    gate <= v;
  endtask
  // reset levels, register map and unmapped places
  task automatic t_regs();
    chk("hold", 32'(hold), 32'h1);
    chk("ramp", 32'(rr), 32'h1);
    rd(STATUS_OFFSET, 32'h00000030, RESP_OKAY);
    rd(CTRL_OFFSET, CTRL_RESET_VALUE, RESP_OKAY);
    rd(4'h8, 32'h0, RESP_SLVERR);
    wr(4'hc, 32'h3, RESP_SLVERR);
    rd(CTRL_OFFSET, CTRL_RESET_VALUE, RESP_OKAY);
  endtask
  // gated and triggered runs, clean stop on the square
  task automatic t_run(input logic [1:0] m);
    wr(CTRL_OFFSET, 32'(m), RESP_OKAY);
    repeat (20) @(negedge clk);
    chk("run", 32'(run), 32'h0);
    pin_gate(1'b0);
    repeat (8) @(negedge clk);
    chk("run", 32'(run), 32'h1);
    chk("loop_en", 32'(len), 32'h1);
    pin_gate(1'b1);
    while (run === 1'b1) @(negedge clk);
    chk("loop_en", 32'(len), 32'h1);
    while (len === 1'b1) @(negedge clk);
    chk("square", 32'(sq), 32'h1);
    repeat (40) @(negedge clk);
    chk("stopped", 32'({run, len}), 32'h0);
  endtask
  // single sweep, then release of the held peak
  task automatic t_sweep(input logic [1:0] m);
    int n;
    n = 0;
    // gated first clears a sweep left in hold
    wr(CTRL_OFFSET, 32'(BSS_MODE_GATED), RESP_OKAY);
    wr(CTRL_OFFSET, 32'(m), RESP_OKAY);
    pin_gate(1'b0);
    while (os !== 1'b1) @(negedge clk);
    while (os === 1'b1) begin
      n++;
      @(negedge clk);
    end
    chk("delay", 32'(n), 32'(ONE_SHOT_CYCLES));
    @(negedge clk);
    chk("start_stop", 32'(ss), 32'h1);
    chk("actives", 32'({clr, aa, ab, rr}), 32'he);
    while (ss === 1'b1) @(negedge clk);
    chk("peak", 32'(pk), 32'h1);
    chk("ended", 32'({aa, ab, rr, hold}), 32'h2);
    pin_gate(1'b1);
    repeat (30) @(negedge clk);
    chk("held", 32'(hold), 32'h0);
    pin_gate(1'b0);
    repeat (8) @(negedge clk);
    if (m == BSS_MODE_TRIG_SWEEP) begin
      chk("hold", 32'(hold), 32'h1);
      while (ss !== 1'b1) @(negedge clk);
      while (ss === 1'b1) @(negedge clk);
      repeat (100) @(negedge clk);
      chk("one", 32'({os, ss, hold}), 32'h0);
      wr(CTRL_OFFSET, 32'(m) | 32'h4, RESP_OKAY);
      repeat (4) @(negedge clk);
      chk("soft", 32'({os, hold}), 32'h3);
      while (ss !== 1'b1) @(negedge clk);
      while (ss === 1'b1) @(negedge clk);
    end else begin
      chk("kept", 32'({os, hold}), 32'h0);
      @(posedge clk);
      rst_ctl <= 1'b1;
      repeat (4) @(posedge clk);
      rst_ctl <= 1'b0;
      repeat (8) @(negedge clk);
      chk("freed", 32'(hold), 32'h1);
    end
    pin_gate(1'b1);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    {rst_n, rst_ctl, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    gate = 1'b1;
    {fails, n_compared, cyc} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_run(BSS_MODE_GATED);
    t_run(BSS_MODE_TRIGGERED);
    t_sweep(BSS_MODE_TRIG_SWEEP);
    t_sweep(BSS_MODE_SWEEP_HOLD);
    final_report();
  end
endmodule
`default_nettype wire
